// ### hdl/cts_pkg.sv
package cts_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTS_OFS_CTRL_STD  = 8'h00;
  localparam logic [7:0] CTS_OFS_CTRL_ENH  = 8'h04;
  localparam logic [7:0] CTS_OFS_VALUE_STD = 8'h08;
  localparam logic [7:0] CTS_OFS_VALUE_ENH = 8'h0C;
  localparam logic [7:0] CTS_OFS_TMR_ASSIGN = 8'h10;
  localparam logic [7:0] CTS_OFS_FLAGS     = 8'h14;
  localparam logic [7:0] CTS_OFS_CAN_IO    = 8'h18;
  localparam logic [7:0] CTS_OFS_PIN_DIR   = 8'h1C;
  localparam logic [7:0] CTS_OFS_PORT_LAT  = 8'h20;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTS_CTRL_MODE_LSB = 0;
  localparam int unsigned CTS_CTRL_DUTY_LSB = 4;
  localparam logic [3:0]  CTS_MODE_RST      = 4'h0;
  localparam logic [1:0]  CTS_DUTY_RST      = 2'h0;
  localparam logic [15:0] CTS_VALUE_RST     = 16'h0000;
  localparam logic [1:0]  CTS_ASSIGN_RST    = 2'h0;
  localparam logic [1:0]  CTS_DIR_RST       = 2'h3;
  localparam logic [1:0]  CTS_LATCH_RST     = 2'h0;
  localparam logic [9:0]  CTS_PWM_DUTY_RST  = 10'h000;
  localparam logic [2:0]  CTS_HSIZE_WORD    = 3'h2;

  // ----------------------------------------------------------------
  // mode codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CTS_MODE_OFF      = 4'h0;
  localparam logic [3:0] CTS_MODE_CMP_TGL  = 4'h2;
  localparam logic [3:0] CTS_MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] CTS_MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] CTS_MODE_CAP_DIV4 = 4'h6;
  localparam logic [3:0] CTS_MODE_CAP_D16  = 4'h7;
  localparam logic [3:0] CTS_MODE_CMP_HI   = 4'h8;
  localparam logic [3:0] CTS_MODE_CMP_LO   = 4'h9;
  localparam logic [3:0] CTS_MODE_CMP_SW   = 4'hA;
  localparam logic [3:0] CTS_MODE_CMP_TRIG = 4'hB;

  // prescaler masks: fire when the low count bits are all ones
  localparam logic [3:0] CTS_PRE_MASK_1  = 4'h0;
  localparam logic [3:0] CTS_PRE_MASK_4  = 4'h3;
  localparam logic [3:0] CTS_PRE_MASK_16 = 4'hF;

  typedef enum logic [1:0] {
    CTS_CLS_OFF,
    CTS_CLS_CAPTURE,
    CTS_CLS_COMPARE,
    CTS_CLS_PWM
  } cts_class_t;

  function automatic cts_class_t cts_class(input logic [3:0] mode);
    cts_class_t c;
    c = CTS_CLS_OFF;
    if (mode[3:2] == 2'h3)
      c = CTS_CLS_PWM;
    else if (mode[3:2] == 2'h1)
      c = CTS_CLS_CAPTURE;
    else if (mode == CTS_MODE_CMP_TGL || mode[3:2] == 2'h2)
      c = CTS_CLS_COMPARE;
    return c;
  endfunction

endpackage

// ### hdl/cts_prescaler.sv
`timescale 1ns/1ps

module cts_prescaler (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // control
  input  wire logic       clear,
  input  wire logic [3:0] mask,
  // events
  input  wire logic       event_in,
  output logic            fire
);
  import cts_pkg::*;

  logic [3:0] cnt_r;
  logic       at_end;

  // a count left over from another divisor is kept, so the first
  // capture after a direct switch may come early
  assign at_end = (cnt_r & mask) == mask;
  assign fire   = event_in & at_end & ~clear;

  always_ff @(posedge clk) begin
    if (!rst_b || clear) begin
      cnt_r <= 4'h0;
    end else if (event_in) begin
      cnt_r <= at_end ? 4'h0 : cnt_r + 4'h1;
    end
  end

endmodule

// ### hdl/cts_top.sv
`timescale 1ns/1ps

module cts_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // shared timers
  input  wire logic [15:0] first_timer_count,
  input  wire logic [15:0] second_timer_count,
  input  wire logic        pwm_period_tick,
  output logic             first_timer_clear,
  output logic             second_timer_clear,
  output logic             adc_start,
  // can receive strobe
  input  wire logic        can_rx_strobe,
  // standard unit pin
  input  wire logic        std_pin_in,
  output logic             std_pin_out,
  output logic             std_pin_oe,
  // enhanced unit pin
  input  wire logic        enh_pin_in,
  output logic             enh_pin_out,
  output logic             enh_pin_oe,
  // flags and pwm duty
  output logic             std_event_flag,
  output logic             enh_event_flag,
  output logic [9:0]       std_pwm_duty,
  output logic [9:0]       enh_pwm_duty
);
  import cts_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [3:0]  mode_r [2];
  logic [1:0]  duty_r [2];
  logic [1:0]  assign_r;
  logic        ts_sel_r;
  logic [1:0]  dir_in_r;
  logic [1:0]  port_lat_r;
  logic [1:0]  flag_r;
  logic [1:0]  lvl_prev_r;
  logic [1:0]  match_prev_r;
  logic [1:0]  cmp_lat_r;
  logic [9:0]  pwm_duty_r [2];
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic        first_clr_r;
  logic        second_clr_r;
  logic        adc_start_r;
  logic [31:0] hrdata_r;
  logic        hready_r;

  logic [1:0]  pin_raw;
  logic [1:0]  lvl;
  logic [15:0] tb_count [2];
  logic [15:0] value [2];
  logic [1:0]  raw_ev;
  logic [1:0]  qual_ev;
  logic [1:0]  cap_fire;
  logic [1:0]  pre_clr;
  logic [3:0]  pre_mask [2];
  logic [1:0]  cmp_hit;
  logic [1:0]  cmp_flag;
  logic [1:0]  trig;
  logic [1:0]  wr_ctrl;
  logic [1:0]  wr_value;
  logic        wr_flags;
  logic        addr_take;
  logic        wr_ok;
  cts_class_t  cls [2];

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  // zero wait states: read data is registered in the address phase,
  // writes land at the end of the data phase
  assign addr_take = hsel & htrans[1] & hready;
  assign wr_ok     = addr_take & hwrite & (hsize == CTS_HSIZE_WORD);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= wr_ok & (haddr[31:8] == 24'h000000);
      wr_addr_r <= haddr[7:0];
    end
  end

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      CTS_OFS_CTRL_STD:   d[5:0] = {duty_r[0], mode_r[0]};
      CTS_OFS_CTRL_ENH:   d[5:0] = {duty_r[1], mode_r[1]};
      CTS_OFS_VALUE_STD:  d[15:0] = value[0];
      CTS_OFS_VALUE_ENH:  d[15:0] = value[1];
      CTS_OFS_TMR_ASSIGN: d[1:0] = assign_r;
      CTS_OFS_FLAGS:      d[1:0] = flag_r;
      CTS_OFS_CAN_IO:     d[0] = ts_sel_r;
      CTS_OFS_PIN_DIR:    d[1:0] = dir_in_r;
      CTS_OFS_PORT_LAT:   d[1:0] = port_lat_r;
      default:            d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hrdata_r <= 32'h0000_0000;
    end else if (addr_take && !hwrite) begin
      hrdata_r <= (haddr[31:8] == 24'h000000) ? rd_mux(haddr[7:0])
                                              : 32'h0000_0000;
    end
  end

  // low while in reset so no transfer is taken before the block is up
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hready_r <= 1'b0;
    end else begin
      hready_r <= 1'b1;
    end
  end

  assign hreadyout = hready_r;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // ----------------------------------------------------------------
  // write strobes
  // ----------------------------------------------------------------
  assign wr_ctrl[0]  = wr_pend_r & (wr_addr_r == CTS_OFS_CTRL_STD);
  assign wr_ctrl[1]  = wr_pend_r & (wr_addr_r == CTS_OFS_CTRL_ENH);
  assign wr_value[0] = wr_pend_r & (wr_addr_r == CTS_OFS_VALUE_STD);
  assign wr_value[1] = wr_pend_r & (wr_addr_r == CTS_OFS_VALUE_ENH);
  assign wr_flags    = wr_pend_r & (wr_addr_r == CTS_OFS_FLAGS);

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int u = 0; u < 2; u++) begin
        mode_r[u] <= CTS_MODE_RST;
        duty_r[u] <= CTS_DUTY_RST;
      end
    end else begin
      for (int u = 0; u < 2; u++) begin
        if (wr_ctrl[u]) begin
          mode_r[u] <= hwdata[CTS_CTRL_MODE_LSB +: 4];
          duty_r[u] <= hwdata[CTS_CTRL_DUTY_LSB +: 2];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      assign_r   <= CTS_ASSIGN_RST;
      ts_sel_r   <= 1'b0;
      dir_in_r   <= CTS_DIR_RST;
      port_lat_r <= CTS_LATCH_RST;
    end else if (wr_pend_r) begin
      if (wr_addr_r == CTS_OFS_TMR_ASSIGN)
        assign_r <= hwdata[1:0];
      if (wr_addr_r == CTS_OFS_CAN_IO)
        ts_sel_r <= hwdata[0];
      if (wr_addr_r == CTS_OFS_PIN_DIR)
        dir_in_r <= hwdata[1:0];
      if (wr_addr_r == CTS_OFS_PORT_LAT)
        port_lat_r <= hwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // time base selection
  // ----------------------------------------------------------------
  // each unit owns one assignment bit, so two capturing units may
  // sit on different timers or share one
  always_comb begin
    for (int u = 0; u < 2; u++) begin
      cls[u]      = cts_class(mode_r[u]);
      tb_count[u] = assign_r[u] ? second_timer_count
                                : first_timer_count;
    end
  end

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  // an output-configured pin reads back its port latch, so a port
  // write that changes the latch looks like an edge
  assign pin_raw = {enh_pin_in, std_pin_in};

  always_comb begin
    for (int u = 0; u < 2; u++) begin
      lvl[u] = dir_in_r[u] ? pin_raw[u] : port_lat_r[u];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lvl_prev_r <= 2'h0;
    end else begin
      lvl_prev_r <= lvl;
    end
  end

  // the edge history keeps running across mode changes; a change may
  // thus see an edge at once, which software masks and clears
  always_comb begin
    for (int u = 0; u < 2; u++) begin
      if (u == 0 && ts_sel_r)
        raw_ev[u] = can_rx_strobe;
      else if (mode_r[u] == CTS_MODE_CAP_FALL)
        raw_ev[u] = ~lvl[u] & lvl_prev_r[u];
      else
        raw_ev[u] = lvl[u] & ~lvl_prev_r[u];
      qual_ev[u] = raw_ev[u] & (cls[u] == CTS_CLS_CAPTURE);
      pre_clr[u] = cls[u] != CTS_CLS_CAPTURE;
      if (mode_r[u] == CTS_MODE_CAP_D16)
        pre_mask[u] = CTS_PRE_MASK_16;
      else if (mode_r[u] == CTS_MODE_CAP_DIV4)
        pre_mask[u] = CTS_PRE_MASK_4;
      else
        pre_mask[u] = CTS_PRE_MASK_1;
    end
  end

  // ----------------------------------------------------------------
  // per unit prescaler and capture store
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_unit
    // divisor switch without a clear keeps the count
    cts_prescaler u_pre (
      .clk      (clk),
      .rst_b    (rst_b),
      .clear    (pre_clr[g]),
      .mask     (pre_mask[g]),
      .event_in (qual_ev[g]),
      .fire     (cap_fire[g])
    );

    cts_value_reg u_val (
      .clk      (clk),
      .rst_b    (rst_b),
      .hw_load  (cap_fire[g]),
      .hw_value (tb_count[g]),
      .sw_load  (wr_value[g]),
      .sw_value (hwdata[15:0]),
      .value    (value[g])
    );
  end

  // ----------------------------------------------------------------
  // compare
  // ----------------------------------------------------------------
  always_comb begin
    for (int u = 0; u < 2; u++) begin
      cmp_hit[u]  = (cls[u] == CTS_CLS_COMPARE) & ~match_prev_r[u]
                    & (value[u] == tb_count[u]);
      cmp_flag[u] = cmp_hit[u];
      trig[u]     = cmp_hit[u] & (mode_r[u] == CTS_MODE_CMP_TRIG);
    end
  end

  // only the first cycle of a match counts, a stalled timer would
  // otherwise flag again every cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      match_prev_r <= 2'h0;
    end else begin
      for (int u = 0; u < 2; u++) begin
        match_prev_r[u] <= (cls[u] == CTS_CLS_COMPARE)
                           & (value[u] == tb_count[u]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmp_lat_r <= 2'h0;
    end else begin
      for (int u = 0; u < 2; u++) begin
        if (mode_r[u] == CTS_MODE_OFF)
          cmp_lat_r[u] <= 1'b0;
        else if (wr_ctrl[u] && hwdata[3:0] == CTS_MODE_CMP_HI)
          cmp_lat_r[u] <= 1'b0;
        else if (wr_ctrl[u] && hwdata[3:0] == CTS_MODE_CMP_LO)
          cmp_lat_r[u] <= 1'b1;
        else if (cmp_hit[u]) begin
          unique case (mode_r[u])
            CTS_MODE_CMP_TGL: cmp_lat_r[u] <= ~cmp_lat_r[u];
            CTS_MODE_CMP_HI:  cmp_lat_r[u] <= 1'b1;
            CTS_MODE_CMP_LO:  cmp_lat_r[u] <= 1'b0;
            default:          cmp_lat_r[u] <= cmp_lat_r[u];
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // timer clear and conversion start
  // ----------------------------------------------------------------
  // a clear goes to whichever timer the unit is assigned; a capture
  // unit on the same timer then sees the restarted count
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      first_clr_r  <= 1'b0;
      second_clr_r <= 1'b0;
      adc_start_r  <= 1'b0;
    end else begin
      first_clr_r  <= (trig[0] & ~assign_r[0])
                      | (trig[1] & ~assign_r[1]);
      second_clr_r <= (trig[0] & assign_r[0])
                      | (trig[1] & assign_r[1]);
      adc_start_r  <= trig[1];
    end
  end

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  // write one to clear; a set in the same cycle wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flag_r <= 2'h0;
    end else begin
      flag_r <= (flag_r & ~({2{wr_flags}} & hwdata[1:0]))
                | cap_fire | cmp_flag;
    end
  end

  // ----------------------------------------------------------------
  // pwm duty reload
  // ----------------------------------------------------------------
  // both units reload on the one period tick, so they share a rate
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int u = 0; u < 2; u++) begin
        pwm_duty_r[u] <= CTS_PWM_DUTY_RST;
      end
    end else begin
      for (int u = 0; u < 2; u++) begin
        if (cls[u] == CTS_CLS_PWM && pwm_period_tick)
          pwm_duty_r[u] <= {value[u][7:0], duty_r[u]};
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      std_pin_out <= 1'b0;
      std_pin_oe  <= 1'b0;
      enh_pin_out <= 1'b0;
      enh_pin_oe  <= 1'b0;
    end else begin
      std_pin_out <= (cls[0] == CTS_CLS_COMPARE) ? cmp_lat_r[0]
                                                 : port_lat_r[0];
      std_pin_oe  <= ~dir_in_r[0];
      enh_pin_out <= (cls[1] == CTS_CLS_COMPARE) ? cmp_lat_r[1]
                                                 : port_lat_r[1];
      enh_pin_oe  <= ~dir_in_r[1];
    end
  end

  assign first_timer_clear  = first_clr_r;
  assign second_timer_clear = second_clr_r;
  assign adc_start          = adc_start_r;
  assign std_event_flag     = flag_r[0];
  assign enh_event_flag     = flag_r[1];
  assign std_pwm_duty       = pwm_duty_r[0];
  assign enh_pwm_duty       = pwm_duty_r[1];

endmodule

// ### hdl/cts_value_reg.sv
`timescale 1ns/1ps

module cts_value_reg (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // hardware capture
  input  wire logic        hw_load,
  input  wire logic [15:0] hw_value,
  // software write
  input  wire logic        sw_load,
  input  wire logic [15:0] sw_value,
  // stored pair
  output logic [15:0]      value
);
  import cts_pkg::*;

  // a capture in the same cycle as a bus write wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      value <= CTS_VALUE_RST;
    end else if (hw_load) begin
      value <= hw_value;
    end else if (sw_load) begin
      value <= sw_value;
    end
  end

endmodule

// ### verif/cts_event_src.sv
`timescale 1ns/1ps

module cts_event_src (
  // clock
  input wire logic clk,
  // pin levels and receive strobe
  output logic     std_lvl,
  output logic     enh_lvl,
  output logic     can_rx_strobe
);
  initial begin
    std_lvl = 1'b0;
    enh_lvl = 1'b0;
    can_rx_strobe = 1'b0;
  end
  // a level holds a full cycle so the unit sees one clean edge
  task automatic pins(input logic s, input logic e);
    @(posedge clk);
    std_lvl <= s;
    enh_lvl <= e;
    @(posedge clk);
  endtask
  task automatic can_msg();
    @(posedge clk);
    can_rx_strobe <= 1'b1;
    @(posedge clk);
    can_rx_strobe <= 1'b0;
  endtask
endmodule

// ### verif/cts_properties.sv
`timescale 1ns/1ps

module cts_properties (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // period tick and unit outputs
  input wire logic        pwm_period_tick,
  input wire logic        first_timer_clear,
  input wire logic        second_timer_clear,
  input wire logic        adc_start,
  input wire logic        std_pin_oe,
  input wire logic        std_event_flag,
  input wire logic        enh_event_flag,
  input wire logic [9:0]  std_pwm_duty
);
  import cts_pkg::*;
  logic       wr_r;
  logic [7:0] wa_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----
  // write data-phase tracker
  // ----
  always_ff @(posedge clk) begin
    wr_r <= hsel && htrans[1] && hready && hwrite;
    wa_r <= haddr[7:0];
  end
  sequence s_trig_over;
    ##1 !first_timer_clear && !second_timer_clear && !adc_start;
  endsequence
  property p_ready; 1 |=> hreadyout; endproperty
  property p_okay; hresp == 1'b0; endproperty
  property p_rdata;
    $changed(hrdata) |-> $past(hsel && htrans[1] && hready && !hwrite);
  endproperty
  // flags may lag the clearing write by one register stage
  property p_flag_std;
    $fell(std_event_flag) |-> $past(wr_r && wa_r == CTS_OFS_FLAGS) ||
      $past(wr_r && wa_r == CTS_OFS_FLAGS, 2);
  endproperty
  property p_flag_enh;
    $fell(enh_event_flag) |-> $past(wr_r && wa_r == CTS_OFS_FLAGS) ||
      $past(wr_r && wa_r == CTS_OFS_FLAGS, 2);
  endproperty
  property p_trig;
    first_timer_clear || second_timer_clear |-> s_trig_over;
  endproperty
  property p_adc; adc_start |-> first_timer_clear || second_timer_clear;
  endproperty
  property p_oe;
    $changed(std_pin_oe) |-> $past(wr_r && wa_r == CTS_OFS_PIN_DIR) ||
      $past(wr_r && wa_r == CTS_OFS_PIN_DIR, 2);
  endproperty
  property p_duty; $changed(std_pwm_duty) |-> $past(pwm_period_tick);
  endproperty
  a_ready: assert property (p_ready) else $error("ready low");
  a_okay: assert property (p_okay) else $error("error response");
  a_rdata: assert property (p_rdata) else $error("read data moved");
  a_flag_std: assert property (p_flag_std)
    else $error("standard flag cleared by hardware");
  a_flag_enh: assert property (p_flag_enh)
    else $error("enhanced flag cleared by hardware");
  a_trig: assert property (p_trig) else $error("trigger too long");
  a_adc: assert property (p_adc) else $error("lone conversion");
  a_oe: assert property (p_oe) else $error("drive changed alone");
  a_duty: assert property (p_duty) else $error("duty off tick");
endmodule

bind cts_top cts_properties i_props (.clk, .rst_b, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .hrdata, .pwm_period_tick,
  .first_timer_clear, .second_timer_clear, .adc_start, .std_pin_oe,
  .std_event_flag, .enh_event_flag, .std_pwm_duty);

// ### verif/cts_top_tb.sv
`timescale 1ns/1ps

module cts_top_tb;
  import cts_pkg::*;
  logic        clk, rst_b, hwrite, hready, hresp, tick, can;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [15:0] t1, t2;
  logic        clr1, clr2, adc, lvl_s, lvl_e, pin_s, pin_e;
  logic        out_s, out_e, oe_s, oe_e, flag_s, flag_e;
  logic [9:0]  duty_s, duty_e;
  int          n_mismatch, checks_done;
  assign pin_s = oe_s ? out_s : lvl_s;
  assign pin_e = oe_e ? out_e : lvl_e;
  cts_top i_dut (.clk, .rst_b, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(CTS_HSIZE_WORD), .hwdata, .hready, .hreadyout(hready), .hresp,
    .hrdata, .first_timer_count(t1), .second_timer_count(t2),
    .pwm_period_tick(tick), .first_timer_clear(clr1),
    .second_timer_clear(clr2), .adc_start(adc), .can_rx_strobe(can),
    .std_pin_in(pin_s), .std_pin_out(out_s), .std_pin_oe(oe_s),
    .enh_pin_in(pin_e), .enh_pin_out(out_e), .enh_pin_oe(oe_e),
    .std_event_flag(flag_s), .enh_event_flag(flag_e),
    .std_pwm_duty(duty_s), .enh_pwm_duty(duty_e));
  cts_event_src i_src (.clk, .std_lvl(lvl_s), .enh_lvl(lvl_e),
    .can_rx_strobe(can));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // timers run synchronously and honour the trigger clear
  always @(posedge clk) begin
    t1 <= clr1 ? 16'h0000 : t1 + 16'h0001;
    t2 <= clr2 ? 16'h0000 : t2 + 16'h0001;
  end
  // ----
  // bus and check helpers
  // ----
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ev(input bit c);
    if (c)
      i_src.can_msg();
    else begin
      i_src.pins(1'b0, 1'b0);
      i_src.pins(1'b1, 1'b0);
    end
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    logic [31:0] q;
    rd(CTS_OFS_PIN_DIR, q);
    chk("direction", {30'h0, CTS_DIR_RST}, q);
    rd(8'h40, q);
    chk("unmapped", 32'h0, q);
    $display("reset test done");
  endtask
  task automatic t_edges();
    logic [31:0] q;
    logic [15:0] e;
    wr(CTS_OFS_CTRL_STD, {28'h0, CTS_MODE_CAP_RISE});
    wr(CTS_OFS_FLAGS, 32'h3);
    i_src.pins(1'b1, 1'b0);
    i_src.pins(1'b0, 1'b0);
    i_src.pins(1'b1, 1'b0);
    e = t1;
    rd(CTS_OFS_VALUE_STD, q);
    chk("rise value", {16'h0, e}, q);
    chk("rise flag", 32'h1, {31'h0, flag_s});
    wr(CTS_OFS_CTRL_STD, {28'h0, CTS_MODE_CAP_FALL});
    i_src.pins(1'b0, 1'b0);
    e = t1;
    i_src.pins(1'b1, 1'b0);
    rd(CTS_OFS_VALUE_STD, q);
    chk("fall value", {16'h0, e}, q);
    $display("edge test done");
  endtask
  task automatic t_count(input bit c, input logic [3:0] m, input int n);
    logic [31:0] v0, q;
    logic [15:0] e;
    wr(CTS_OFS_CTRL_STD, {28'h0, m});
    repeat (2) ev(c);
    wr(CTS_OFS_CTRL_STD, 32'h0);
    wr(CTS_OFS_CTRL_STD, {28'h0, m});
    wr(CTS_OFS_FLAGS, 32'h3);
    rd(CTS_OFS_VALUE_STD, v0);
    if (c)
      ev(1'b0);
    repeat (n - 1) ev(c);
    rd(CTS_OFS_VALUE_STD, q);
    chk("early value", v0, q);
    ev(c);
    e = t1;
    rd(CTS_OFS_VALUE_STD, q);
    chk("counted value", {16'h0, e}, q);
    chk("counted flag", 32'h1, {31'h0, flag_s});
    $display("count test mode %h done", m);
  endtask
  task automatic t_assign();
    logic [31:0] q;
    logic [15:0] e, e2;
    wr(CTS_OFS_TMR_ASSIGN, 32'h1);
    wr(CTS_OFS_CTRL_STD, {28'h0, CTS_MODE_CAP_RISE});
    wr(CTS_OFS_CTRL_ENH, {28'h0, CTS_MODE_CAP_RISE});
    i_src.pins(1'b0, 1'b0);
    i_src.pins(1'b1, 1'b1);
    e = t2;
    e2 = t1;
    rd(CTS_OFS_VALUE_STD, q);
    chk("second timer", {16'h0, e}, q);
    rd(CTS_OFS_VALUE_ENH, q);
    chk("first timer", {16'h0, e2}, q);
    $display("assign test done");
  endtask
  task automatic t_outpin();
    int i;
    i_src.pins(1'b0, 1'b0);
    wr(CTS_OFS_PORT_LAT, 32'h0);
    wr(CTS_OFS_PIN_DIR, 32'h2);
    wr(CTS_OFS_FLAGS, 32'h3);
    chk("pin drive", 32'h1, {31'h0, oe_s});
    wr(CTS_OFS_PORT_LAT, 32'h1);
    for (i = 0; i < 8 && flag_s !== 1'b1; i++)
      @(posedge clk);
    chk("port capture", 32'h1, {31'h0, flag_s});
    wr(CTS_OFS_PIN_DIR, 32'h3);
    $display("output pin test done");
  endtask
  task automatic t_cmp();
    logic [31:0] q;
    logic [15:0] e;
    int i;
    wr(CTS_OFS_TMR_ASSIGN, 32'h3);
    wr(CTS_OFS_VALUE_ENH, {16'h0, t2 + 16'h0100});
    wr(CTS_OFS_CTRL_ENH, {28'h0, CTS_MODE_CMP_TRIG});
    for (i = 0; i < 600 && clr2 !== 1'b1; i++)
      @(posedge clk);
    chk("timer clear", 32'h1, {31'h0, clr2});
    chk("conversion", 32'h1, {31'h0, adc});
    chk("other clear", 32'h0, {31'h0, clr1});
    i_src.pins(1'b1, 1'b0);
    e = t2;
    wr(CTS_OFS_CTRL_ENH, {28'h0, CTS_MODE_CMP_LO});
    rd(CTS_OFS_VALUE_STD, q);
    chk("after clear", {16'h0, e}, q);
    chk("enh latch", 32'h1, {31'h0, out_e});
    wr(CTS_OFS_CTRL_ENH, 32'h0);
    $display("compare test done");
  endtask
  task automatic t_pwm();
    wr(CTS_OFS_VALUE_STD, 32'hAB);
    wr(CTS_OFS_VALUE_ENH, 32'h5C);
    wr(CTS_OFS_CTRL_STD, 32'h2C);
    wr(CTS_OFS_CTRL_ENH, 32'h1C);
    chk("duty held", 32'h0, {22'h0, duty_s});
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    @(posedge clk);
    chk("std duty", 32'h2AE, {22'h0, duty_s});
    chk("enh duty", 32'h171, {22'h0, duty_e});
    $display("pwm test done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    {rst_b, hwrite, tick, htrans, haddr, hwdata} = '0;
    t1 = 16'h1000;
    t2 = 16'h8000;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_edges();
    t_count(1'b0, CTS_MODE_CAP_DIV4, 4);
    t_count(1'b0, CTS_MODE_CAP_D16, 16);
    wr(CTS_OFS_CAN_IO, 32'h1);
    for (int k = 0; k < 4; k++)
      t_count(1'b1, 4'h4 + 4'(k), k < 2 ? 1 : (k == 2 ? 4 : 16));
    wr(CTS_OFS_CAN_IO, 32'h0);
    t_assign();
    t_outpin();
    t_cmp();
    t_pwm();
    summarize();
  end
endmodule
